/* bps_seq.sv */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "bps_defines.svh"
module bps_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bps_pkg::bps_bus_req_s bus_req_i,
  output logic [31:0] bus_rdata_o,
  input wire logic vco_tick_i,
  input wire logic pll_tick_i,
  input wire logic external_clock_port_i,
  input wire logic external_trigger_input_i,
  output logic pulse_out_o,
  output logic strobe_out_o,
  output logic channel_one_output_on_o
);
  bps_pkg::bps_ctrl_s ctrl_q;
  logic [15:0] burst_m1_q;
  logic [13:0] len_m1_q, cursor_q, walk_q, stop_q, rnd_left_q;
  logic [3:0] order_q;
  logic [31:0] rdata_q;
  logic [1:0] sy1_q, sy2_q, sy3_q, lvl_q, lvl_p_q;
  logic [`BPS_PAT_BITS-1:0] data_w_q, strb_w_q, data_o_q, strb_o_q;
  bps_pkg::bps_edit_e ed_q;
  bps_pkg::bps_cmd_e op_q, cmd;
  logic tgt_q, run_q, ph_q, pulse_q, strobe_q;
  logic [15:0] cnt_q, seq_end;
  logic [1:0] rise;
  logic cmd_wr, edit_ok, fire, upd_now, tgt, tick, start_ok, seq_done;
  logic wr_en, wr_both, wr_val, rnd_bit, rnd_load, rnd_step;
  logic [13:0] wr_idx, new_m1;
  bps_pkg::bps_period_e per_src;

  function automatic logic [16:0] sat(input logic [16:0] v, input logic [16:0] lo,
                                      input logic [16:0] hi);
    sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // high bits saturate instead of wrapping back into range
  function automatic logic [16:0] low17(input logic [31:0] w);
    low17 = (|w[31:17]) ? 17'h1FFFF : w[16:0];
  endfunction

  function automatic logic pat_bit(input logic [13:0] i);
    pat_bit = tgt ? strb_w_q[i] : data_w_q[i];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 trigger input, bit 1 external clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_q <= 2'h0;
      sy2_q <= 2'h0;
      sy3_q <= 2'h0;
      lvl_q <= 2'h0;
      lvl_p_q <= 2'h0;
    end else begin
      sy1_q <= {external_clock_port_i, external_trigger_input_i};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      // a change counts only once the two late stages agree
      lvl_q <= (sy2_q & ~(sy2_q ^ sy3_q)) | (lvl_q & (sy2_q ^ sy3_q));
      lvl_p_q <= lvl_q;
    end
  end
  assign rise = lvl_q & ~lvl_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  assign cmd_wr = bus_req_i.we && bus_req_i.addr == `BPS_OFF_CMD;
  assign cmd = bps_pkg::bps_cmd_e'(bus_req_i.wdata[`BPS_CMD_LSB +: 4]);
  assign edit_ok = cmd_wr && ed_q == bps_pkg::ED_IDLE;
  assign fire = cmd_wr && cmd == bps_pkg::CMD_MANUAL_FIRE;
  assign upd_now = cmd_wr && cmd == bps_pkg::CMD_UPDATE_NOW;
  assign new_m1 = 14'(sat(low17(bus_req_i.wdata), `BPS_LEN_MIN, `BPS_LEN_MAX) - 17'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= bps_pkg::bps_ctrl_s'(`BPS_CTRL_RST);
      burst_m1_q <= `BPS_BURST_RST;
      order_q <= `BPS_ORDER_RST;
    end else if (bus_req_i.we) begin
      case (bus_req_i.addr)
        `BPS_OFF_CTRL: ctrl_q <= bps_pkg::bps_ctrl_s'(bus_req_i.wdata[`BPS_CTRL_W-1:0]);
        `BPS_OFF_BURST:
          burst_m1_q <= 16'(sat(low17(bus_req_i.wdata), `BPS_BURST_MIN, `BPS_BURST_MAX)
                            - 17'h1);
        `BPS_OFF_ORDER: begin
          // order stays put while a random fill runs
          if (ed_q == bps_pkg::ED_IDLE) begin
            order_q <= 4'(sat({13'h0, bus_req_i.wdata[3:0]} | {12'h0, |bus_req_i.wdata[31:4],
                          4'h0}, `BPS_ORDER_MIN, `BPS_ORDER_MAX));
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else if (bus_req_i.re) begin
      case (bus_req_i.addr)
        `BPS_OFF_CTRL: rdata_q <= {20'h0, ctrl_q};
        `BPS_OFF_BURST: rdata_q <= {15'h0, 17'(burst_m1_q) + 17'h1};
        `BPS_OFF_LEN: rdata_q <= {17'h0, 15'(len_m1_q) + 15'h1};
        `BPS_OFF_CURSOR: rdata_q <= {18'h0, cursor_q};
        `BPS_OFF_ORDER: rdata_q <= {28'h0, order_q};
        `BPS_OFF_STATUS:
          rdata_q <= {cnt_q, 12'h0, strobe_q, pulse_q, run_q, ed_q == bps_pkg::ED_WALK};
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end
  assign bus_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // edit engine: one bit per cycle, so a full-length walk takes 16384 cycles
  assign tgt = (ed_q == bps_pkg::ED_WALK) ? tgt_q : ctrl_q.strobe_target;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ed_q <= bps_pkg::ED_IDLE;
      op_q <= bps_pkg::CMD_SET0;
      tgt_q <= 1'b0;
      walk_q <= 14'h0;
      stop_q <= 14'h0;
      rnd_left_q <= 14'h0;
      len_m1_q <= `BPS_LEN_RST;
      cursor_q <= 14'h0;
    end else if (ed_q == bps_pkg::ED_WALK) begin
      if (walk_q == stop_q || (op_q == bps_pkg::CMD_INSERT_RANDOM && rnd_left_q == 14'h1)) begin
        ed_q <= bps_pkg::ED_IDLE;
      end else begin
        walk_q <= (op_q == bps_pkg::CMD_INSERT) ? walk_q - 14'h1 : walk_q + 14'h1;
      end
      rnd_left_q <= rnd_left_q - 14'h1;
    end else if (bus_req_i.we && bus_req_i.addr == `BPS_OFF_LEN) begin
      len_m1_q <= new_m1;
      if (cursor_q > new_m1) begin
        cursor_q <= new_m1;
      end
      // clear the dropped tail so a later growth reads zeros
      if (new_m1 < len_m1_q) begin
        op_q <= bps_pkg::CMD_SHRINK;
        walk_q <= new_m1 + 14'h1;
        stop_q <= len_m1_q;
        ed_q <= bps_pkg::ED_WALK;
      end
    end else if (bus_req_i.we && bus_req_i.addr == `BPS_OFF_CURSOR) begin
      cursor_q <= (bus_req_i.wdata[13:0] > len_m1_q) ? len_m1_q : bus_req_i.wdata[13:0];
    end else if (edit_ok) begin
      op_q <= cmd;
      tgt_q <= ctrl_q.strobe_target;
      walk_q <= cursor_q;
      stop_q <= len_m1_q;
      rnd_left_q <= 14'((15'h1 << order_q) - 15'h1);
      case (cmd)
        bps_pkg::CMD_SET0, bps_pkg::CMD_SET1, bps_pkg::CMD_TOGGLE: begin
          if (cursor_q != len_m1_q) begin
            cursor_q <= cursor_q + 14'h1;
          end
        end
        bps_pkg::CMD_FILL1, bps_pkg::CMD_FILL0, bps_pkg::CMD_INVERT,
        bps_pkg::CMD_DELETE, bps_pkg::CMD_INSERT_RANDOM: begin
          ed_q <= bps_pkg::ED_WALK;
        end
        bps_pkg::CMD_INSERT: begin
          // insert at the last bit only drops the copy
          if (cursor_q != len_m1_q) begin
            walk_q <= len_m1_q;
            stop_q <= cursor_q + 14'h1;
            ed_q <= bps_pkg::ED_WALK;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    wr_en = 1'b0;
    wr_both = 1'b0;
    wr_idx = walk_q;
    wr_val = 1'b0;
    rnd_step = 1'b0;
    if (ed_q == bps_pkg::ED_WALK) begin
      wr_en = 1'b1;
      case (op_q)
        bps_pkg::CMD_FILL1: wr_val = 1'b1;
        bps_pkg::CMD_INVERT: wr_val = ~pat_bit(walk_q);
        bps_pkg::CMD_INSERT: wr_val = pat_bit(walk_q - 14'h1);
        bps_pkg::CMD_DELETE:
          wr_val = (walk_q == len_m1_q) ? 1'b0 : pat_bit(walk_q + 14'h1);
        bps_pkg::CMD_INSERT_RANDOM: begin
          wr_val = rnd_bit;
          rnd_step = 1'b1;
        end
        bps_pkg::CMD_SHRINK: wr_both = 1'b1;
        default: wr_val = 1'b0;
      endcase
    end else if (edit_ok && (cmd == bps_pkg::CMD_SET0 || cmd == bps_pkg::CMD_SET1 ||
                             cmd == bps_pkg::CMD_TOGGLE)) begin
      wr_en = 1'b1;
      wr_idx = cursor_q;
      wr_val = (cmd == bps_pkg::CMD_TOGGLE) ? ~pat_bit(cursor_q) :
               (cmd == bps_pkg::CMD_SET1);
    end
  end

  assign rnd_load = edit_ok && cmd == bps_pkg::CMD_INSERT_RANDOM;

  bps_prbs u_prbs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(rnd_load),
    .step_i(rnd_step),
    .order_i(order_q),
    .bit_o(rnd_bit)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_w_q <= '0;
      strb_w_q <= '0;
    end else if (wr_en) begin
      if (wr_both || !tgt) begin
        data_w_q[wr_idx] <= wr_val;
      end
      if (wr_both || tgt) begin
        strb_w_q[wr_idx] <= wr_val;
      end
    end
  end

  // output copy; deferred mode holds the old pattern until told
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o_q <= '0;
      strb_o_q <= '0;
    end else if (ctrl_q.update_continuous || upd_now) begin
      data_o_q <= data_w_q;
      strb_o_q <= strb_w_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: each tick is a half period
  always_comb begin
    per_src = ctrl_q.period_origin_select;
    if (ctrl_q.trigger_behaviour_select == bps_pkg::TRG_SINGLE &&
        ctrl_q.trigger_origin_select == bps_pkg::ORG_PLL) begin
      per_src = bps_pkg::PER_VCO;
    end
    case (per_src)
      bps_pkg::PER_PLL: tick = pll_tick_i;
      bps_pkg::PER_EXT_CLOCK: tick = rise[1];
      default: tick = vco_tick_i;
    endcase
    case (ctrl_q.trigger_behaviour_select)
      bps_pkg::TRG_FREE: start_ok = 1'b1;
      bps_pkg::TRG_GATED: start_ok = rise[0];
      bps_pkg::TRG_SINGLE: begin
        case (ctrl_q.trigger_origin_select)
          bps_pkg::ORG_PLL: start_ok = pll_tick_i;
          bps_pkg::ORG_MANUAL: start_ok = fire;
          default: start_ok = rise[0];
        endcase
      end
      default: start_ok = 1'b0;
    endcase
  end

  assign seq_end = (ctrl_q.mode_select == bps_pkg::MODE_PATTERN) ? {2'h0, len_m1_q} :
                   burst_m1_q;
  assign seq_done = run_q && tick && ph_q && cnt_q >= seq_end;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_q.channel_one_output_on ||
        ctrl_q.mode_select == bps_pkg::MODE_EDGE_FOLLOW) begin
      run_q <= 1'b0;
      ph_q <= 1'b0;
      cnt_q <= 16'h0;
    end else if (!run_q) begin
      if (start_ok) begin
        run_q <= 1'b1;
      end
    end else if (tick) begin
      ph_q <= ~ph_q;
      if (ph_q) begin
        if (cnt_q >= seq_end) begin
          cnt_q <= 16'h0;
          run_q <= ctrl_q.trigger_behaviour_select == bps_pkg::TRG_FREE ||
                   (ctrl_q.trigger_behaviour_select == bps_pkg::TRG_GATED && lvl_q[0]);
        end else begin
          cnt_q <= cnt_q + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_q.channel_one_output_on) begin
      pulse_q <= 1'b0;
      strobe_q <= 1'b0;
    end else if (ctrl_q.mode_select == bps_pkg::MODE_EDGE_FOLLOW) begin
      // timing registers are not consulted here at all
      pulse_q <= lvl_q[0];
      strobe_q <= 1'b0;
    end else if (run_q && ctrl_q.mode_select == bps_pkg::MODE_PATTERN) begin
      pulse_q <= data_o_q[cnt_q[13:0]] & (~ctrl_q.format_rz | ~ph_q);
      strobe_q <= strb_o_q[cnt_q[13:0]];
    end else begin
      pulse_q <= run_q && !ph_q;
      strobe_q <= 1'b0;
    end
  end

  assign pulse_out_o = pulse_q;
  assign strobe_out_o = strobe_q;
  assign channel_one_output_on_o = ctrl_q.channel_one_output_on;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_burst_bound: assert property (
    run_q && ctrl_q.mode_select == bps_pkg::MODE_BURST |-> cnt_q <= burst_m1_q)
    else $error("burst index past programmed count");
  a_single_stops: assert property (
    seq_done && ctrl_q.trigger_behaviour_select == bps_pkg::TRG_SINGLE &&
    $stable(ctrl_q) |=> !run_q && cnt_q == 16'h0)
    else $error("single burst did not stop at its end");
  a_free_repeat: assert property (
    seq_done && ctrl_q.trigger_behaviour_select == bps_pkg::TRG_FREE &&
    $stable(ctrl_q) |=> run_q && cnt_q == 16'h0)
    else $error("free run did not repeat");
  a_manual_start: assert property (
    !run_q && ctrl_q.channel_one_output_on && fire &&
    ctrl_q.mode_select == bps_pkg::MODE_BURST &&
    ctrl_q.trigger_behaviour_select == bps_pkg::TRG_SINGLE &&
    ctrl_q.trigger_origin_select == bps_pkg::ORG_MANUAL |=> run_q ##1 pulse_q)
    else $error("manual fire did not start a burst");
  a_gate_last: assert property (
    seq_done && ctrl_q.trigger_behaviour_select == bps_pkg::TRG_GATED && !lvl_q[0] &&
    $stable(ctrl_q) |=> !run_q)
    else $error("burst repeated after gate closed");
  a_edge_track: assert property (
    ctrl_q.channel_one_output_on && ctrl_q.mode_select == bps_pkg::MODE_EDGE_FOLLOW &&
    $rose(lvl_q[0]) |=> pulse_q)
    else $error("output missed a trigger edge");
  a_off_quiet: assert property (
    !ctrl_q.channel_one_output_on |=> !pulse_q && !strobe_q && !run_q)
    else $error("output active while disabled");
  a_cursor_step: assert property (
    edit_ok && cmd == bps_pkg::CMD_SET1 && cursor_q < len_m1_q |=>
    cursor_q == $past(cursor_q) + 14'h1 && pat_bit($past(cursor_q)))
    else $error("bit edit did not set and advance");
  a_len_range: assert property (
    len_m1_q != 14'h0 && cursor_q <= len_m1_q)
    else $error("length or cursor out of range");

  c_free_wrap: cover property (seq_done && ctrl_q.trigger_behaviour_select == bps_pkg::TRG_FREE);
  c_random_fill: cover property (ed_q == bps_pkg::ED_WALK && op_q == bps_pkg::CMD_INSERT_RANDOM);
  c_edge_mode: cover property (ctrl_q.mode_select == bps_pkg::MODE_EDGE_FOLLOW && $fell(pulse_q));
endmodule

/* bps_defines.svh */
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH
// register offsets (byte addresses)
`define BPS_OFF_CTRL 8'h00
`define BPS_OFF_BURST 8'h04
`define BPS_OFF_LEN 8'h08
`define BPS_OFF_CURSOR 8'h0C
`define BPS_OFF_ORDER 8'h10
`define BPS_OFF_CMD 8'h14
`define BPS_OFF_STATUS 8'h18
// control word: width and reset (rz format, continuous update)
`define BPS_CTRL_W 12
`define BPS_CTRL_RST 12'h600
// field positions
`define BPS_CMD_LSB 0
`define BPS_STAT_CNT 16
// ranges and resets
`define BPS_BURST_MIN 17'h00002
`define BPS_BURST_MAX 17'h10000
`define BPS_BURST_RST 16'h0001
`define BPS_LEN_MIN 17'h00002
`define BPS_LEN_MAX 17'h04000
`define BPS_LEN_RST 14'h000F
`define BPS_ORDER_MIN 17'h00005
`define BPS_ORDER_MAX 17'h0000E
`define BPS_ORDER_RST 4'h7
`define BPS_PAT_BITS 16384
`define BPS_LFSR_SEED 14'h0001
`endif

/* bps_pkg.sv */
package bps_pkg;
  typedef enum logic [1:0] {MODE_BURST, MODE_PATTERN, MODE_EDGE_FOLLOW} bps_mode_e;
  typedef enum logic [1:0] {TRG_FREE, TRG_SINGLE, TRG_GATED} bps_behaviour_e;
  typedef enum logic [1:0] {ORG_EXTERNAL, ORG_PLL, ORG_MANUAL} bps_origin_e;
  typedef enum logic [1:0] {PER_VCO, PER_PLL, PER_EXT_CLOCK} bps_period_e;
  typedef enum logic [3:0] {
    CMD_SET0, CMD_SET1, CMD_TOGGLE, CMD_FILL1, CMD_FILL0, CMD_INVERT,
    CMD_INSERT, CMD_DELETE, CMD_INSERT_RANDOM, CMD_UPDATE_NOW,
    CMD_MANUAL_FIRE, CMD_SHRINK
  } bps_cmd_e;
  typedef enum logic {ED_IDLE, ED_WALK} bps_edit_e;
  typedef struct packed {
    logic strobe_target;
    logic update_continuous;
    logic format_rz;
    bps_period_e period_origin_select;
    bps_origin_e trigger_origin_select;
    bps_behaviour_e trigger_behaviour_select;
    bps_mode_e mode_select;
    logic channel_one_output_on;
  } bps_ctrl_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } bps_bus_req_s;
endpackage

/* bps_prbs.sv */
`timescale 1ns/10ps
`include "bps_defines.svh"
module bps_prbs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic [3:0] order_i,
  output logic bit_o
);
  logic [13:0] lfsr_q;

  // feedback taps of a maximal-length polynomial for each order
  function automatic logic [13:0] tap_mask(input logic [3:0] n);
    case (n)
      4'h5: tap_mask = 14'h0014;
      4'h6: tap_mask = 14'h0030;
      4'h7: tap_mask = 14'h0060;
      4'h8: tap_mask = 14'h00B8;
      4'h9: tap_mask = 14'h0110;
      4'hA: tap_mask = 14'h0240;
      4'hB: tap_mask = 14'h0500;
      4'hC: tap_mask = 14'h0829;
      4'hD: tap_mask = 14'h100D;
      4'hE: tap_mask = 14'h2015;
      default: tap_mask = 14'h0014;
    endcase
  endfunction

  // stages above n carry junk but never feed back
  always_ff @(posedge clk_i) begin
    if (rst_i || load_i) begin
      lfsr_q <= `BPS_LFSR_SEED;
    end else if (step_i) begin
      lfsr_q <= {lfsr_q[12:0], ^(lfsr_q & tap_mask(order_i))};
    end
  end

  assign bit_o = lfsr_q[order_i - 4'h1];
endmodule

/* bps_partner.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far side: trigger pin, vco and pll ticks, edge counters on the output stage
module bps_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gate_i,
  input wire logic pll_fire_i,
  input wire logic pulse_i,
  input wire logic strobe_i,
  output logic vco_tick_o,
  output logic pll_tick_o,
  output logic ext_trig_o,
  output logic ext_clock_o,
  output logic [15:0] pulse_count_o,
  output logic [15:0] strobe_count_o
);
  logic [1:0] div_q;
  logic pulse_q;
  logic strobe_q;
  // clock pin stands still: every test paces periods from the vco
  assign ext_clock_o = 1'b0;
  assign ext_trig_o = gate_i;
  assign pll_tick_o = pll_fire_i;
  // half period of four cycles, so one output period spans eight
  assign vco_tick_o = (div_q == 2'h3);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  // rising edges only: rz ones count singly, nrz runs merge into one
  always_ff @(posedge clk_i) begin
    pulse_q <= pulse_i;
    strobe_q <= strobe_i;
    if (rst_i) begin
      pulse_count_o <= 16'h0000;
      strobe_count_o <= 16'h0000;
    end else begin
      if (pulse_i && !pulse_q) begin
        pulse_count_o <= pulse_count_o + 16'h0001;
      end
      if (strobe_i && !strobe_q) begin
        strobe_count_o <= strobe_count_o + 16'h0001;
      end
    end
  end
endmodule

/* bps_seq_bench.sv */
`timescale 1ns/10ps
`include "bps_defines.svh"
module bps_seq_bench;
  logic clk_i;
  logic rst_i;
  bps_pkg::bps_bus_req_s req;
  logic [31:0] rdata;
  logic vco_tick, pll_tick, ext_clk, ext_trig, pulse, strobe, ch_on;
  logic gate, pll_fire;
  logic [15:0] pcnt, scnt, p, s, p0, s0;
  logic [31:0] v;
  int err_count, checked;
  logic [7:0] ra [7] = '{`BPS_OFF_CTRL, `BPS_OFF_BURST, `BPS_OFF_LEN, `BPS_OFF_CURSOR,
                         `BPS_OFF_ORDER, `BPS_OFF_CMD, 8'h1C};
  logic [31:0] rv [7] = '{32'h600, 32'h2, 32'h10, 32'h0, 32'h7, 32'h0, 32'h0};
  logic [7:0] ca [7] = '{`BPS_OFF_BURST, `BPS_OFF_BURST, `BPS_OFF_BURST, `BPS_OFF_LEN,
                         `BPS_OFF_LEN, `BPS_OFF_ORDER, `BPS_OFF_ORDER};
  logic [31:0] cw [7] = '{32'h1, 32'h10000, 32'h20000, 32'h1, 32'h5000, 32'h4, 32'hF};
  logic [31:0] ce [7] = '{32'h2, 32'h10000, 32'h10000, 32'h2, 32'h4000, 32'h5, 32'hE};
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  bps_seq dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
    .vco_tick_i(vco_tick), .pll_tick_i(pll_tick), .external_clock_port_i(ext_clk),
    .external_trigger_input_i(ext_trig), .pulse_out_o(pulse), .strobe_out_o(strobe),
    .channel_one_output_on_o(ch_on)
  );
  bps_partner part_u (
    .clk_i(clk_i), .rst_i(rst_i), .gate_i(gate), .pll_fire_i(pll_fire), .pulse_i(pulse),
    .strobe_i(strobe), .vco_tick_o(vco_tick), .pll_tick_o(pll_tick), .ext_trig_o(ext_trig),
    .ext_clock_o(ext_clk), .pulse_count_o(pcnt), .strobe_count_o(scnt)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    req <= '0;
    // read data stand only in the cycle after the strobe
    #1 d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // bounded poll on a status bit; a stuck bit shows as a count mismatch later
  task automatic poll(input int b);
    int n;
    n = 0;
    v = 32'hF;
    while (v[b] !== 1'b0 && n < 20000) begin
      rd(`BPS_OFF_STATUS, v);
      n++;
    end
  endtask
  task automatic cmd(input logic [3:0] c);
    wr(`BPS_OFF_CMD, {28'h0, c});
    poll(0);
  endtask
  task automatic drain(output logic [15:0] dp, output logic [15:0] ds);
    repeat (10) @(posedge clk_i);
    poll(1);
    repeat (4) @(posedge clk_i);
    gate <= 1'b0;
    dp = pcnt - p0;
    ds = scnt - s0;
  endtask
  // how: 0 manual fire, 1 trigger pin edge, 2 pll tick
  task automatic shot(input int how);
    p0 = pcnt;
    s0 = scnt;
    if (how == 0) begin
      cmd(4'hA);
    end else if (how == 1) begin
      @(posedge clk_i);
      gate <= 1'b1;
    end else begin
      @(posedge clk_i);
      pll_fire <= 1'b1;
      @(posedge clk_i);
      pll_fire <= 1'b0;
    end
    drain(p, s);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end
  initial begin
    req = '0;
    gate = 1'b0;
    pll_fire = 1'b0;
    rst_i = 1'b1;
    err_count = 0;
    checked = 0;
    s = 16'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rc(ra[i], rv[i]);
    for (int i = 0; i < 7; i++) begin
      wr(ca[i], cw[i]);
      // a shrink keeps the engine busy and would swallow the next length write
      poll(0);
      rc(ca[i], ce[i]);
    end
    // burst mode, one start source at a time
    wr(`BPS_OFF_BURST, 32'h2);
    wr(`BPS_OFF_CTRL, 32'h649);
    shot(0);
    chk({16'h0, p}, 32'h2);
    wr(`BPS_OFF_BURST, 32'h3);
    shot(0);
    chk({16'h0, p}, 32'h3);
    wr(`BPS_OFF_CTRL, 32'h609);
    shot(1);
    chk({16'h0, p}, 32'h3);
    wr(`BPS_OFF_CTRL, 32'h6A9);
    shot(2);
    chk({16'h0, p}, 32'h3);
    // gate open for several bursts, the closing edge finishes the current one
    wr(`BPS_OFF_CTRL, 32'h611);
    p0 = pcnt;
    @(posedge clk_i);
    gate <= 1'b1;
    repeat (100) @(posedge clk_i);
    gate <= 1'b0;
    drain(p, s);
    chk({16'h0, p % 16'h3}, 32'h0);
    chk({31'h0, p >= 16'h9}, 32'h1);
    p0 = pcnt;
    wr(`BPS_OFF_CTRL, 32'h601);
    repeat (200) @(posedge clk_i);
    chk({31'h0, (pcnt - p0) >= 16'd20}, 32'h1);
    wr(`BPS_OFF_CTRL, 32'h600);
    repeat (3) @(posedge clk_i);
    p0 = pcnt;
    #1 chk({31'h0, pulse}, 32'h0);
    chk({31'h0, ch_on}, 32'h0);
    repeat (50) @(posedge clk_i);
    chk({16'h0, pcnt}, {16'h0, p0});
    // edge follow: output is the pin level, whatever timing is programmed
    wr(`BPS_OFF_CTRL, 32'h605);
    @(posedge clk_i);
    gate <= 1'b1;
    repeat (100) @(posedge clk_i);
    #1 chk({31'h0, pulse}, 32'h1);
    chk({31'h0, ch_on}, 32'h1);
    @(posedge clk_i);
    gate <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1 chk({31'h0, pulse}, 32'h0);
    chk({16'h0, pcnt - p0}, 32'h1);
    // pattern mode, rz data: pulse count equals the number of ones
    wr(`BPS_OFF_LEN, 32'h8);
    wr(`BPS_OFF_CTRL, 32'h64B);
    shot(0);
    chk({16'h0, p}, 32'h0);
    wr(`BPS_OFF_CURSOR, 32'h2);
    cmd(4'h1);
    cmd(4'h1);
    cmd(4'h2);
    rc(`BPS_OFF_CURSOR, 32'h5);
    shot(0);
    chk({16'h0, p}, 32'h3);
    wr(`BPS_OFF_CURSOR, 32'h6);
    cmd(4'h3);
    shot(0);
    chk({16'h0, p}, 32'h5);
    wr(`BPS_OFF_CURSOR, 32'h6);
    cmd(4'h5);
    shot(0);
    chk({16'h0, p}, 32'h3);
    wr(`BPS_OFF_CURSOR, 32'h2);
    cmd(4'h6);
    shot(0);
    chk({16'h0, p}, 32'h4);
    wr(`BPS_OFF_CURSOR, 32'h7);
    cmd(4'h3);
    wr(`BPS_OFF_CURSOR, 32'h2);
    cmd(4'h7);
    shot(0);
    chk({16'h0, p}, 32'h4);
    // same bits in nrz: adjacent ones merge into one pulse
    wr(`BPS_OFF_CTRL, 32'h44B);
    shot(0);
    chk({16'h0, p}, 32'h2);
    wr(`BPS_OFF_CTRL, 32'hE4B);
    wr(`BPS_OFF_CURSOR, 32'h0);
    cmd(4'h1);
    cmd(4'h1);
    wr(`BPS_OFF_CURSOR, 32'h7);
    cmd(4'h1);
    shot(0);
    chk({16'h0, p}, 32'h4);
    chk({16'h0, s}, 32'h2);
    // shrinking clears the tail of both patterns; regrown bits are zero
    wr(`BPS_OFF_LEN, 32'h4);
    poll(0);
    wr(`BPS_OFF_LEN, 32'h8);
    rc(`BPS_OFF_LEN, 32'h8);
    shot(0);
    chk({16'h0, p}, 32'h2);
    chk({16'h0, s}, 32'h1);
    wr(`BPS_OFF_CTRL, 32'h24B);
    wr(`BPS_OFF_CURSOR, 32'h0);
    cmd(4'h1);
    shot(0);
    chk({16'h0, p}, 32'h2);
    cmd(4'h9);
    shot(0);
    chk({16'h0, p}, 32'h3);
    // order 5 gives 31 bits, 16 of them ones, placed exactly in 9..39
    wr(`BPS_OFF_CTRL, 32'h64B);
    wr(`BPS_OFF_LEN, 32'h28);
    wr(`BPS_OFF_CURSOR, 32'h9);
    wr(`BPS_OFF_ORDER, 32'h5);
    cmd(4'h8);
    shot(0);
    chk({16'h0, p}, 32'h13);
    end_of_test();
  end
endmodule
